// ===== logic/dbg_status_pkg.sv
// debug status flags: register map, field positions and reset values
// assumes a 32-bit apb slave with one aligned word per register
package dbg_status_pkg;
    // register byte offsets
    localparam logic [7:0] status_off  = 8'h00;
    localparam logic [7:0] control_off = 8'h04;
    // status fields
    localparam int stopped_pos = 7;
    localparam int halt_pos    = 6;
    localparam int rprot_pos   = 5;
    // control fields
    localparam int debug_mode_bit_pos = 7;
    localparam int breakpoint_enable_bit_pos   = 6;
    localparam int breakpoint_loop_bit_pos = 4;
    localparam logic [7:0] control_rst = 8'h00;
    localparam logic [7:0] bp_opcode   = 8'h00;
    localparam logic [31:0] rdata_rst  = 32'h0000_0000;

    typedef struct packed {
        logic       valid;
        logic [7:0] opcode;
    } decode_t;
endpackage

// ===== logic/debug_status_flags.sv
// debug status flags with its debug control register behind an apb slave
// assumes decode, halt and read-protect option inputs synchronous to pclk
`timescale 1ns/100ps
// Overview of operation
// - stopped flag at bit 7 reads 1 whenever the debug mode bit is 1.
// - stopped flag stays 1 after a taken breakpoint until next control write.
// - bit 6 reads 1 while the device is in halt mode.
// - bit 5 reads the inverse of the stored read-protect option bit.
// - debug mode stops fetch; breakpoint with loop off sets debug mode.
// - breakpoint with loop on makes the cpu repeat the breakpoint.
// - under read protection debug mode cannot be cleared by a write.
module debug_status_flags
    import dbg_status_pkg::*;
(
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // cpu side
    input  wire decode_t     decode,
    input  wire logic        halt_mode,
    input  wire logic        rprot_opt_bit,
    output logic             fetch_stop,
    output logic             bp_repeat
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] control_q;
    logic       bp_seen_q;
    logic       halt_q;
    logic       rprot_q;
    logic       setup;
    logic       wr_ctl;
    logic       bp_hit;
    logic [7:0] status;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    assign setup  = psel && !penable;
    assign wr_ctl = psel && penable && pready && pwrite && hit(paddr, control_off);
    assign bp_hit = decode.valid && decode.opcode == bp_opcode
                    && control_q[breakpoint_enable_bit_pos];

    ////////////////////////////////////////////////////////////////////////
    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_q <= control_rst;
        end else begin
            if (wr_ctl) begin
                control_q <= pwdata[7:0] & 8'hd0;
                if (rprot_q && control_q[debug_mode_bit_pos])
                    control_q[debug_mode_bit_pos] <= 1'b1;
            end
            if (bp_hit && !control_q[breakpoint_loop_bit_pos])
                control_q[debug_mode_bit_pos] <= 1'b1;
        end
    end

    // breakpoint-seen flag; set wins over the clearing write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bp_seen_q <= 1'b0;
        end else if (bp_hit) begin
            bp_seen_q <= 1'b1;
        end else if (wr_ctl) begin
            bp_seen_q <= 1'b0;
        end
    end

    // sampled state inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_q  <= 1'b0;
            rprot_q <= 1'b0;
        end else begin
            halt_q  <= halt_mode;
            rprot_q <= !rprot_opt_bit;
        end
    end

    // cpu control outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_stop <= 1'b0;
            bp_repeat  <= 1'b0;
        end else begin
            fetch_stop <= control_q[debug_mode_bit_pos];
            bp_repeat  <= bp_hit && control_q[breakpoint_loop_bit_pos];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        status = 8'h00;
        status[stopped_pos] = control_q[debug_mode_bit_pos] || bp_seen_q;
        status[halt_pos]    = halt_q;
        status[rprot_pos]   = rprot_q;
    end

    // apb: no wait states, pready rises in the first access cycle; read data captured at setup; status writes dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= rdata_rst;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !hit(paddr, status_off) && !hit(paddr, control_off);
            if (setup && !pwrite) begin
                if (hit(paddr, status_off))
                    prdata <= {24'h000000, status};
                else if (hit(paddr, control_off))
                    prdata <= {24'h000000, control_q};
                else
                    prdata <= rdata_rst;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_stop_mode;
        @(posedge pclk) disable iff (!presetn)
        control_q[debug_mode_bit_pos] |-> status[stopped_pos];
    endproperty
    a_stop_mode: assert property (p_stop_mode) else $error("stopped low in debug mode");

    property p_bp_hold;
        @(posedge pclk) disable iff (!presetn)
        bp_hit ##1 !wr_ctl |=> status[stopped_pos];
    endproperty
    a_bp_hold: assert property (p_bp_hold) else $error("stopped lost after breakpoint");

    property p_halt;
        @(posedge pclk) disable iff (!presetn)
        $past(presetn) |-> status[halt_pos] == $past(halt_mode);
    endproperty
    a_halt: assert property (p_halt) else $error("halt flag mismatch");

    property p_rprot;
        @(posedge pclk) disable iff (!presetn)
        $past(presetn) |-> status[rprot_pos] == !$past(rprot_opt_bit);
    endproperty
    a_rprot: assert property (p_rprot) else $error("read protect flag mismatch");

    property p_reserved;
        @(posedge pclk) disable iff (!presetn)
        pready && !pwrite && hit(paddr, status_off) |-> {prdata[31:8], prdata[4:0]} == 29'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

    property p_wr_ignored;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pwrite && hit(paddr, status_off)
        |=> $stable(control_q) || $past(bp_hit);
    endproperty
    a_wr_ignored: assert property (p_wr_ignored) else $error("status write changed ctl");

    property p_bp_mode;
        @(posedge pclk) disable iff (!presetn)
        bp_hit && !control_q[breakpoint_loop_bit_pos] |-> ##2 fetch_stop;
    endproperty
    a_bp_mode: assert property (p_bp_mode) else $error("breakpoint did not stop fetch");

    property p_loop;
        @(posedge pclk) disable iff (!presetn)
        bp_hit && control_q[breakpoint_loop_bit_pos] && !control_q[debug_mode_bit_pos]
        |=> bp_repeat && !control_q[debug_mode_bit_pos];
    endproperty
    a_loop: assert property (p_loop) else $error("breakpoint loop entered debug mode");

    property p_protect;
        @(posedge pclk) disable iff (!presetn)
        rprot_q && control_q[debug_mode_bit_pos] |=> control_q[debug_mode_bit_pos];
    endproperty
    a_protect: assert property (p_protect) else $error("mode cleared under protection");

    ////////////////////////////////////////////////////////////////////////
    // bus-side and output checks
    property p_rd_stop;
        @(posedge pclk) disable iff (!presetn)
        pready && !pwrite && hit(paddr, status_off) && $past(control_q[debug_mode_bit_pos])
        |-> prdata[stopped_pos];
    endproperty
    a_rd_stop: assert property (p_rd_stop) else $error("stopped bit low on bus read");

    property p_rd_halt;
        @(posedge pclk) disable iff (!presetn)
        pready && !pwrite && hit(paddr, status_off) && $past(presetn, 2)
        |-> prdata[halt_pos] == $past(halt_mode, 2);
    endproperty
    a_rd_halt: assert property (p_rd_halt) else $error("halt bit wrong on bus read");

    property p_rd_rprot;
        @(posedge pclk) disable iff (!presetn)
        pready && !pwrite && hit(paddr, status_off) && $past(presetn, 2)
        |-> prdata[rprot_pos] == !$past(rprot_opt_bit, 2);
    endproperty
    a_rd_rprot: assert property (p_rd_rprot) else $error("protect bit wrong on read");

    property p_wr_clear;
        @(posedge pclk) disable iff (!presetn)
        wr_ctl && !pwdata[debug_mode_bit_pos] && !rprot_q && !bp_hit |=> !status[stopped_pos];
    endproperty
    a_wr_clear: assert property (p_wr_clear) else $error("stopped kept after write");

    property p_rep_idle;
        @(posedge pclk) disable iff (!presetn)
        bp_repeat |-> status[stopped_pos];
    endproperty
    a_rep_idle: assert property (p_rep_idle) else $error("stopped low while looping");

    property p_wr_mode;
        @(posedge pclk) disable iff (!presetn)
        wr_ctl && pwdata[debug_mode_bit_pos] |-> ##2 fetch_stop;
    endproperty
    a_wr_mode: assert property (p_wr_mode) else $error("mode write did not stop fetch");

    property p_fetch;
        @(posedge pclk) disable iff (!presetn)
        $past(presetn) |-> fetch_stop == $past(control_q[debug_mode_bit_pos]);
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch stop lags mode");
endmodule

// ===== testbench/debug_status_flags_tb_top.sv
// bench for debug_status_flags: apb reads and writes, breakpoint decode
// assumes the package offsets and the designer's one-cycle apb answer
`timescale 1ns/100ps
module debug_status_flags_tb_top
    import dbg_status_pkg::*;
;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, e, fetch_stop, bp_repeat;
    logic        halt_mode = 0, rprot_opt_bit = 1;
    decode_t     decode = '0;
    int          errors = 0, n_compared = 0;
    always #2 pclk = ~pclk;
    debug_status_flags debug_status_flags_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .decode(decode), .halt_mode(halt_mode),
        .rprot_opt_bit(rprot_opt_bit), .fetch_stop(fetch_stop), .bp_repeat(bp_repeat));
    ////////////////////////////////////////////////////////////////////////////////
    task conclude;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task check(input logic [31:0] s, input logic [31:0] x);
        n_compared++;
        if (s !== x) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, s, x);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        if (n >= 50) begin
            errors++;
            conclude;
        end
        psel <= 0; penable <= 0;
    endtask
    task stat(input logic [7:0] x);
        apb(0, status_off, 32'h0);
        check(r, {24'h0, x});
    endtask
    task breakpoint_instruction;
        @(posedge pclk) decode <= '{1'b1, bp_opcode};
        @(posedge pclk) decode <= '0;
    endtask
    task rst;
        @(posedge pclk) presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_basic;
        stat(8'h00);
        apb(1, status_off, 32'he0); stat(8'h00);
        apb(0, 8'h08, 32'h0); check({r[31:1], e}, 32'h1);
        halt_mode <= 1; rprot_opt_bit <= 0; stat(8'h60);
        halt_mode <= 0; rprot_opt_bit <= 1; stat(8'h00);
        $display("basic done");
    endtask
    task t_mode;
        apb(1, control_off, 32'h80); stat(8'h80);
        check(fetch_stop, 1);
        apb(1, control_off, 32'h00); stat(8'h00);
        check(fetch_stop, 0);
        $display("mode done");
    endtask
    task t_brk;
        apb(1, control_off, 32'h40); breakpoint_instruction; stat(8'h80);
        check(fetch_stop, 1);
        apb(1, control_off, 32'h50); stat(8'h00);
        breakpoint_instruction;
        @(posedge pclk) check(bp_repeat, 1);
        check(fetch_stop, 0); stat(8'h80);
        apb(1, control_off, 32'h00); stat(8'h00);
        $display("breakpoint done");
    endtask
    task t_prot;
        rprot_opt_bit <= 0;
        apb(1, control_off, 32'h80); apb(1, control_off, 32'h00);
        stat(8'ha0);
        rst; stat(8'h20);
        rprot_opt_bit <= 1;
        $display("protect done");
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        t_basic;
        t_mode;
        t_brk;
        t_prot;
        conclude;
    end
endmodule
